/* axis_far_model.sv */
// far-side model: quadrature encoders, index marks and limit switch chains
`timescale 1ns/1ps
module axis_far_model
  import axis_pkg::*;
(
  input  wire logic        pclk,
  output encoder_pins_type encoder [AXES],
  output logic [AXES-1:0]  limit_in
);
  logic [1:0] ph [AXES];

  // encoders at rest, switch chains closed
  initial begin
    limit_in = '0;
    for (int i = 0; i < AXES; i++) begin
      ph[i] = 2'b00;
      encoder[i] = '0;
    end
  end

  // quarter step, first phase leads going up; rests between edges
  task automatic step(input int ax, input logic up, input logic both);
    logic [1:0] nx;
    nx = both ? ~ph[ax] : (up ? {~ph[ax][0], ph[ax][1]} : {ph[ax][0], ~ph[ax][1]});
    @(posedge pclk);
    encoder[ax].encoder_phase_first  <= nx[1];
    encoder[ax].encoder_phase_second <= nx[0];
    ph[ax] = nx;
    repeat (3) @(posedge pclk);
  endtask

  // index mark lasts four cycles so the synchroniser cannot miss it
  task automatic index_pulse(input int ax);
    @(posedge pclk);
    encoder[ax].encoder_index_pulse <= 1'b1;
    repeat (4) @(posedge pclk);
    encoder[ax].encoder_index_pulse <= 1'b0;
  endtask

  // high = chain open
  task automatic set_limit(input int ax, input logic open);
    @(posedge pclk);
    limit_in[ax] <= open;
  endtask
endmodule

/* axis_motion.sv */
// four-axis motion block: encoders, limits, homing, motor command, i/o, apb registers
//
// Contract
// - decode two quarter-cycle phases, count every edge, direction from phase order
// - a triggered limit forces the axis to init mode with zero motor command
// - limit emergency flag cannot clear while the limit input is still active
// - limit override lets the axis be jogged off an active limit
// - limit triggers after 600 ns active; the switch must hold it 1 us
// - limit is active when the ground contact opens; one input per axis
// - 24 general inputs, 16 general outputs, four dedicated limit inputs
// - actual position keeps counting while the axis sits in a limit
// - drive enable output is low to disable, and low through reset
// - 8-bit spindle code output loaded from a host-written register
// - motor command given as analog level or as pwm per axis format
// - homing input of each axis selectable from any general input
// - stage one moves positive on 0, negative on 1, ends on input change
// - stage two reverses at one fifth speed, ends on next input change
// - stage three stops on the index pulse and zeroes the actual position
// - after power-up the actual position is zero
`timescale 1ns/1ps
module axis_motion
  import axis_pkg::*;
#(
  parameter int POS_W = 32
)(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire encoder_pins_type       encoder [AXES],
  input  wire logic [AXES-1:0]        limit_in,
  input  wire logic [GPI_COUNT-1:0]   gpi_in,
  output logic      [GPO_COUNT-1:0]   gpo_out,
  output motor_out_type               motor [AXES],
  output logic                        drive_enable,
  output logic      [7:0]             spindle_code,
  output logic                        irq
);

  logic [31:0]          ctrl_reg;
  logic [7:0]           status_reg;
  logic [7:0]           mask_reg;
  logic [GPO_COUNT-1:0] gpo_reg;
  logic [7:0]           spindle_reg;
  logic [GPI_COUNT-1:0] gpi_meta_reg;
  logic [GPI_COUNT-1:0] gpi_sync_reg;
  logic [AXES-1:0]      lim_meta_reg;
  logic [AXES-1:0]      lim_sync_reg;
  logic [6:0]           lim_cnt_reg [AXES];
  logic [AXES-1:0]      lim_active_reg;
  logic [AXES-1:0]      lim_trig;
  mode_type             mode_reg [AXES];
  home_state_type       home_reg [AXES];
  logic [AXES-1:0]      home_level_reg;
  logic [AXES-1:0]      homed_pulse;
  logic [4:0]           home_sel_reg [AXES];
  logic [15:0]          vel_reg [AXES];
  logic [15:0]          acc_reg [AXES];
  logic [15:0]          cmd_reg [AXES];
  logic [15:0]          target [AXES];
  logic [POS_W-1:0]     pos_reg [AXES];
  logic [AXES-1:0]      cnt_up;
  logic [AXES-1:0]      cnt_dn;
  logic [AXES-1:0]      idx_seen;
  logic [AXES-1:0]      home_bit;
  logic [7:0]           pwm_cnt_reg;
  logic                 setup;
  logic                 wr_en;
  logic                 axis_hit;
  logic [1:0]           axis_idx;
  logic [31:0]          rd_next;
  logic                 err_next;

  // magnitude of a signed command
  function automatic logic [15:0] mag16(input logic [15:0] v);
    mag16 = v[15] ? 16'(-v) : v;
  endfunction

  // signed speed from magnitude and direction flag (1 = negative)
  function automatic logic [15:0] signed_speed(input logic [15:0] v, input logic neg);
    signed_speed = neg ? 16'(-v) : v;
  endfunction

  // one decoder per axis
  for (genvar g = 0; g < AXES; g++) begin : g_dec
    quad_decoder u_dec (
      .pclk       (pclk),
      .presetn    (presetn),
      .pins       (encoder[g]),
      .count_up   (cnt_up[g]),
      .count_down (cnt_dn[g]),
      .index_seen (idx_seen[g])
    );
  end

  // apb decode: ready in the access phase, two cycles a transfer
  assign setup    = psel && !penable;
  assign wr_en    = psel && penable && pwrite && pready;
  assign axis_hit = (paddr >= AXIS_BASE) && (paddr < AXIS_BASE + 12'(AXES) * AXIS_STRIDE);
  assign axis_idx = 2'((paddr - AXIS_BASE) >> 4);

  // pin inputs pass two flops first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpi_meta_reg <= '0;
      gpi_sync_reg <= '0;
      lim_meta_reg <= '0;
      lim_sync_reg <= '0;
    end else begin
      gpi_meta_reg <= gpi_in;
      gpi_sync_reg <= gpi_meta_reg;
      lim_meta_reg <= limit_in;
      lim_sync_reg <= lim_meta_reg;
    end
  end

  // limit filter: high (chain open) must last 600 ns
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int a = 0; a < AXES; a++) lim_cnt_reg[a] <= 7'h00;
      lim_active_reg <= '0;
    end else begin
      for (int a = 0; a < AXES; a++) begin
        if (!lim_sync_reg[a]) begin
          lim_cnt_reg[a]    <= 7'h00;
          lim_active_reg[a] <= 1'b0;
        end else if (lim_cnt_reg[a] < 7'(LIMIT_CYCLES - 1)) begin
          lim_cnt_reg[a]    <= lim_cnt_reg[a] + 7'h01;
        end else begin
          lim_active_reg[a] <= 1'b1;
        end
      end
    end
  end

  // a limit acts only while its override is off
  always_comb begin
    for (int a = 0; a < AXES; a++) begin
      lim_trig[a] = lim_active_reg[a] && !ctrl_reg[CTRL_OVR_LSB + a];
      home_bit[a] = (home_sel_reg[a] < 5'(GPI_COUNT)) ? gpi_sync_reg[home_sel_reg[a]]
                                                      : 1'b0;
    end
  end

  // global control, outputs and spindle code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg    <= CTRL_RST;
      mask_reg    <= 8'h00;
      gpo_reg     <= '0;
      spindle_reg <= SPINDLE_RST;
    end else if (wr_en) begin
      unique case (paddr)
        CTRL_OFF:    ctrl_reg    <= pwdata;
        MASK_OFF:    mask_reg    <= pwdata[7:0];
        GPO_OFF:     gpo_reg     <= pwdata[GPO_COUNT-1:0];
        SPINDLE_OFF: spindle_reg <= pwdata[7:0];
        default:     ;
      endcase
    end
  end

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= 8'h00;
    end else begin
      for (int a = 0; a < AXES; a++) begin
        if (lim_active_reg[a]) begin
          status_reg[ST_LIM_LSB + a] <= 1'b1;
        end else if (wr_en && paddr == STATUS_OFF && pwdata[ST_LIM_LSB + a]) begin
          status_reg[ST_LIM_LSB + a] <= 1'b0;
        end
        if (homed_pulse[a]) begin
          status_reg[ST_HOME_LSB + a] <= 1'b1;
        end else if (wr_en && paddr == STATUS_OFF && pwdata[ST_HOME_LSB + a]) begin
          status_reg[ST_HOME_LSB + a] <= 1'b0;
        end
      end
    end
  end

  // per-axis host settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int a = 0; a < AXES; a++) begin
        vel_reg[a]      <= VEL_RST;
        acc_reg[a]      <= ACC_RST;
        home_sel_reg[a] <= 5'h00;
      end
    end else if (wr_en && axis_hit) begin
      unique case (paddr[3:0])
        AX_MODE_OFF: home_sel_reg[axis_idx] <= pwdata[AX_SEL_LSB +: 5];
        AX_VEL_OFF:  vel_reg[axis_idx]      <= pwdata[15:0];
        AX_ACC_OFF:  acc_reg[axis_idx]      <= pwdata[15:0];
        default:     ;
      endcase
    end
  end

  // mode and homing sequence per axis
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int a = 0; a < AXES; a++) begin
        mode_reg[a] <= MODE_INIT;
        home_reg[a] <= HOME_IDLE;
      end
      home_level_reg <= '0;
      homed_pulse    <= '0;
    end else begin
      homed_pulse <= '0;
      for (int a = 0; a < AXES; a++) begin
        if (lim_trig[a]) begin
          mode_reg[a] <= MODE_INIT;
          home_reg[a] <= HOME_IDLE;
        end else if (wr_en && axis_hit && axis_idx == 2'(a) && paddr[3:0] == AX_MODE_OFF) begin
          mode_reg[a] <= mode_type'(pwdata[1:0]);
          if (pwdata[1:0] == MODE_HOME) begin
            home_reg[a]       <= HOME_SEEK;
            home_level_reg[a] <= home_bit[a];
          end else begin
            home_reg[a]       <= HOME_IDLE;
          end
        end else begin
          unique case (home_reg[a])
            HOME_IDLE:  ;
            HOME_SEEK:  if (home_bit[a] != home_level_reg[a]) home_reg[a] <= HOME_BACK;
            HOME_BACK:  if (home_bit[a] == home_level_reg[a]) home_reg[a] <= HOME_INDEX;
            HOME_INDEX: if (idx_seen[a]) begin
              home_reg[a]    <= HOME_IDLE;
              mode_reg[a]    <= MODE_INIT;
              homed_pulse[a] <= 1'b1;
            end
            default:    home_reg[a] <= HOME_IDLE;
          endcase
        end
      end
    end
  end

  // target speed: seek, then back at a fifth to the index
  always_comb begin
    for (int a = 0; a < AXES; a++) begin
      unique case (home_reg[a])
        HOME_SEEK:  target[a] = signed_speed(vel_reg[a], home_level_reg[a]);
        HOME_BACK,
        HOME_INDEX: target[a] = signed_speed(16'(vel_reg[a] / 16'(HOME_SLOW_DIV)),
                                             !home_level_reg[a]);
        default:    target[a] = (mode_reg[a] == MODE_JOG) ? vel_reg[a] : 16'h0000;
      endcase
    end
  end

  // command ramps to target by the acc step; init or limit snaps it to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int a = 0; a < AXES; a++) cmd_reg[a] <= 16'h0000;
    end else begin
      for (int a = 0; a < AXES; a++) begin
        if (mode_reg[a] == MODE_INIT || lim_trig[a] || (home_reg[a] == HOME_INDEX && idx_seen[a]))
          cmd_reg[a] <= 16'h0000;
        else if ($signed(target[a] - cmd_reg[a]) > $signed(acc_reg[a]))
          cmd_reg[a] <= cmd_reg[a] + acc_reg[a];
        else if ($signed(cmd_reg[a] - target[a]) > $signed(acc_reg[a]))
          cmd_reg[a] <= cmd_reg[a] - acc_reg[a];
        else
          cmd_reg[a] <= target[a];
      end
    end
  end

  // position never stops counting, even in a limit; zero at reset and at the index of homing stage three
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int a = 0; a < AXES; a++) pos_reg[a] <= '0;
    end else begin
      for (int a = 0; a < AXES; a++) begin
        if (home_reg[a] == HOME_INDEX && idx_seen[a]) pos_reg[a] <= '0;
        else if (cnt_up[a])                           pos_reg[a] <= pos_reg[a] + 1'b1;
        else if (cnt_dn[a])                           pos_reg[a] <= pos_reg[a] - 1'b1;
      end
    end
  end

  // motor outputs: analog word or pwm, per axis
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_cnt_reg <= 8'h00;
      for (int a = 0; a < AXES; a++) motor[a] <= '0;
      drive_enable <= 1'b0;
      spindle_code <= SPINDLE_RST;
      gpo_out      <= '0;
      irq          <= 1'b0;
    end else begin
      pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
      for (int a = 0; a < AXES; a++) begin
        motor[a].level    <= ctrl_reg[CTRL_PWM_LSB + a] ? 16'h0000 : cmd_reg[a];
        motor[a].pwm      <= ctrl_reg[CTRL_PWM_LSB + a] &&
                             (mag16(cmd_reg[a]) > {pwm_cnt_reg, 8'h00});
        motor[a].pwm_sign <= ctrl_reg[CTRL_PWM_LSB + a] && cmd_reg[a][15];
      end
      drive_enable <= ctrl_reg[CTRL_EN_BIT];
      spindle_code <= spindle_reg;
      gpo_out      <= gpo_reg;
      irq          <= |(status_reg & mask_reg);
    end
  end

  // read mux, sampled at setup so data are steady in the access phase
  always_comb begin
    rd_next  = 32'h0000_0000;
    err_next = 1'b0;
    if (axis_hit) begin
      unique case (paddr[3:0])
        AX_MODE_OFF: rd_next = {19'h0, home_sel_reg[axis_idx], 3'h0,
                                home_reg[axis_idx], mode_reg[axis_idx]};
        AX_VEL_OFF:  rd_next = {16'h0000, vel_reg[axis_idx]};
        AX_ACC_OFF:  rd_next = {16'h0000, acc_reg[axis_idx]};
        AX_POS_OFF:  rd_next = 32'(pos_reg[axis_idx]);
        default:     err_next = 1'b1;
      endcase
    end else begin
      unique case (paddr)
        CTRL_OFF:    rd_next = ctrl_reg;
        STATUS_OFF:  rd_next = {24'h0, status_reg};
        MASK_OFF:    rd_next = {24'h0, mask_reg};
        GPO_OFF:     rd_next = {16'h0, gpo_reg};
        GPI_OFF:     rd_next = {8'h0, gpi_sync_reg};
        SPINDLE_OFF: rd_next = {24'h0, spindle_reg};
        LIMIT_OFF:   rd_next = {28'h0, lim_active_reg};
        default:     err_next = 1'b1;
      endcase
    end
  end

  // apb answer flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && err_next;
      if (setup && !pwrite) prdata <= rd_next;
    end
  end

endmodule

/* axis_motion_chk.sv */
// bound checker for the motion block's bus and outputs
`timescale 1ns/1ps
module axis_motion_chk
  import axis_pkg::*;
(
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic [AXES-1:0]      limit_in,
  input wire logic [GPO_COUNT-1:0] gpo_out,
  input wire motor_out_type        motor [AXES],
  input wire logic                 drive_enable,
  input wire logic [7:0]           spindle_code
);
  logic        wr_done;
  logic [11:0] ctrl_q;
  logic [7:0]  spin_q;
  logic [15:0] gpo_q;
  logic [7:0]  lim_cnt;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  assign wr_done = psel && penable && pready && pwrite;

  // shadows of the last accepted writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '0;
      spin_q <= '0;
      gpo_q  <= '0;
    end else if (wr_done) begin
      if (paddr == CTRL_OFF) ctrl_q <= pwdata[11:0];
      if (paddr == SPINDLE_OFF) spin_q <= pwdata[7:0];
      if (paddr == GPO_OFF) gpo_q <= pwdata[15:0];
    end
  end

  // axis 0 limit run length, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lim_cnt <= '0;
    else if (!limit_in[0]) lim_cnt <= '0;
    else if (lim_cnt != 8'hff) lim_cnt <= lim_cnt + 8'h01;
  end

  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_drive_stays_off: assert property (
    !ctrl_q[CTRL_EN_BIT] && !$past(ctrl_q[CTRL_EN_BIT]) |-> !drive_enable)
    else $error("drive enabled without control bit");
  a_limit_zero_cmd: assert property (
    lim_cnt > LIMIT_CYCLES + 8 && !ctrl_q[CTRL_OVR_LSB]
    |-> motor[0].level == 16'h0000 && !motor[0].pwm)
    else $error("command not zero in limit");
  a_spindle_load: assert property (
    wr_done && paddr == SPINDLE_OFF |=> ##[0:1] spindle_code == spin_q)
    else $error("spindle code not loaded");
  a_gpo_load: assert property (
    wr_done && paddr == GPO_OFF |=> ##[0:1] gpo_out == gpo_q)
    else $error("outputs not loaded");
  a_pwm_no_level: assert property (
    ctrl_q[CTRL_PWM_LSB] && $past(ctrl_q[CTRL_PWM_LSB], 2) |-> motor[0].level == 16'h0000)
    else $error("level driven in pwm format");

  c_limit_hit: cover property (lim_cnt == 8'd100);
  c_bus_error: cover property (pslverr);
  c_drive_on: cover property ($rose(drive_enable));
endmodule

bind axis_motion axis_motion_chk i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .limit_in(limit_in),
  .gpo_out(gpo_out), .motor(motor), .drive_enable(drive_enable), .spindle_code(spindle_code));

/* axis_motion_test.sv */
// self-checking bench for the four-axis motion block
`timescale 1ns/1ps
module axis_motion_test
  import axis_pkg::*;
;
  typedef struct {logic rd; logic err; logic [31:0] data; logic [31:0] mask;} exp_type;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic                 drive_enable, irq;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, v;
  logic [GPI_COUNT-1:0] gpi_in;
  logic [GPO_COUNT-1:0] gpo_out;
  logic [7:0]           spindle_code;
  logic [AXES-1:0]      limit_in;
  encoder_pins_type     encoder [AXES];
  motor_out_type        motor [AXES];
  exp_type              exp_q [$];
  int                   error_cnt, cmp_count, cyc, up, dn, hs, hi;

  axis_motion i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .encoder(encoder), .limit_in(limit_in), .gpi_in(gpi_in), .gpo_out(gpo_out),
    .motor(motor), .drive_enable(drive_enable), .spindle_code(spindle_code), .irq(irq));
  axis_far_model i_far (.pclk(pclk), .encoder(encoder), .limit_in(limit_in));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic logic [11:0] ax_addr(input int n, input logic [3:0] o);
    return 12'(AXIS_BASE + AXIS_STRIDE * 12'(n) + {8'h0, o});
  endfunction

  // one transfer, held until ready is sampled
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic e);
    exp_q.push_back('{~wr, e, d, m});
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e = 1'b0);
    apb(1'b1, a, d, 32'h0, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d,
                    input logic [31:0] m = 32'hffffffff, input logic e = 1'b0);
    apb(1'b0, a, d, m, e);
  endtask

  // ends mid-cycle so outputs have settled
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic lvl(input int a, input logic [15:0] l);
    check({16'h0, motor[a].level}, {16'h0, l});
  endtask

  // takes the oldest note per finished transfer
  always @(posedge pclk) begin
    exp_type n;
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
      n = exp_q.pop_front();
      check({31'h0, pslverr}, {31'h0, n.err});
      if (n.rd) check(prdata & n.mask, n.data & n.mask);
    end
  end

  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      print_verdict();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, gpi_in} = '0;
    {error_cnt, cmp_count, cyc} = '0;
    void'($urandom(32'hfb888204));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    idle(1);
    check({31'h0, drive_enable}, 32'h0);
    for (int i = 0; i < AXES; i++) begin
      rd(ax_addr(i, AX_POS_OFF), 32'h0);
      rd(ax_addr(i, AX_ACC_OFF), {16'h0, ACC_RST});
    end
    rd(12'h3fc, 32'h0, 32'hffffffff, 1'b1);
    wr(12'h3fc, 32'h1, 1'b1);
    wr(ax_addr(0, AX_POS_OFF), 32'h55);
    rd(ax_addr(0, AX_POS_OFF), 32'h0);
    $display("reset test done");
    // random runs, one illegal double step per axis
    for (int i = 0; i < AXES; i++) begin
      up = $urandom_range(12, 1);
      dn = $urandom_range(6, 0);
      repeat (up) i_far.step(i, 1'b1, 1'b0);
      i_far.step(i, 1'b0, 1'b1);
      repeat (dn) i_far.step(i, 1'b0, 1'b0);
      idle(6);
      if (i == 0) hs = up - dn;
      rd(ax_addr(i, AX_POS_OFF), 32'(up - dn));
    end
    $display("encoder test done");
    for (int k = 0; k < 3; k++) begin
      v = $urandom;
      wr(SPINDLE_OFF, v);
      wr(GPO_OFF, v);
      gpi_in <= v[31:8];
      idle(4);
      check({24'h0, spindle_code}, {24'h0, v[7:0]});
      check({16'h0, gpo_out}, {16'h0, v[15:0]});
      rd(SPINDLE_OFF, {24'h0, v[7:0]});
      rd(GPI_OFF, {8'h0, v[31:8]});
    end
    wr(CTRL_OFF, 32'h1);
    idle(3);
    check({31'h0, drive_enable}, 32'h1);
    $display("io test done");
    wr(ax_addr(0, AX_ACC_OFF), 32'h100);
    wr(ax_addr(0, AX_VEL_OFF), 32'h1000);
    wr(ax_addr(0, AX_MODE_OFF), 32'h1);
    idle(40);
    lvl(0, 16'h1000);
    i_far.set_limit(0, 1'b1);
    repeat (40) @(posedge pclk);
    i_far.set_limit(0, 1'b0);
    idle(8);
    rd(STATUS_OFF, 32'h0, 32'hf);
    wr(MASK_OFF, 32'h1);
    i_far.set_limit(0, 1'b1);
    idle(100);
    lvl(0, 16'h0);
    check({31'h0, irq}, 32'h1);
    rd(STATUS_OFF, 32'h1, 32'hf);
    rd(ax_addr(0, AX_MODE_OFF), 32'h0, 32'h3);
    rd(LIMIT_OFF, 32'h1, 32'hf);
    repeat (3) i_far.step(0, 1'b1, 1'b0);
    idle(6);
    rd(ax_addr(0, AX_POS_OFF), 32'(hs + 3));
    wr(STATUS_OFF, 32'h1);
    rd(STATUS_OFF, 32'h1, 32'hf);
    wr(MASK_OFF, 32'h0);
    idle(3);
    check({31'h0, irq}, 32'h0);
    wr(CTRL_OFF, 32'h11);
    wr(ax_addr(0, AX_MODE_OFF), 32'h1);
    idle(40);
    lvl(0, 16'h1000);
    i_far.set_limit(0, 1'b0);
    wr(ax_addr(0, AX_MODE_OFF), 32'h0);
    wr(CTRL_OFF, 32'h1);
    idle(10);
    wr(STATUS_OFF, 32'h1);
    rd(STATUS_OFF, 32'h0, 32'hf);
    $display("limit test done");
    wr(CTRL_OFF, 32'h101);
    wr(ax_addr(0, AX_MODE_OFF), 32'h1);
    idle(40);
    lvl(0, 16'h0);
    hi = 0;
    repeat (256) begin
      @(negedge pclk);
      hi += motor[0].pwm;
    end
    check(32'(hi), 32'd16);
    wr(ax_addr(0, AX_MODE_OFF), 32'h0);
    wr(CTRL_OFF, 32'h1);
    $display("pwm test done");
    // homing from both sides, random home input
    for (int c = 1; c < 3; c++) begin
      hs = $urandom_range(23, 0);
      gpi_in <= {GPI_COUNT{c[1]}};
      wr(ax_addr(c, AX_ACC_OFF), 32'h100);
      wr(ax_addr(c, AX_VEL_OFF), 32'h1000);
      wr(ax_addr(c, AX_MODE_OFF), 32'(2 + (hs << 8)));
      idle(40);
      lvl(c, c[1] ? 16'hf000 : 16'h1000);
      rd(ax_addr(c, AX_MODE_OFF), 32'h6, 32'h1f);
      gpi_in <= ~gpi_in;
      idle(60);
      lvl(c, c[1] ? 16'h0333 : 16'hfccd);
      rd(ax_addr(c, AX_MODE_OFF), 32'ha, 32'h1f);
      gpi_in <= ~gpi_in;
      idle(10);
      rd(ax_addr(c, AX_MODE_OFF), 32'he, 32'h1f);
      i_far.index_pulse(c);
      idle(10);
      rd(ax_addr(c, AX_MODE_OFF), 32'h0, 32'h1f);
      rd(ax_addr(c, AX_POS_OFF), 32'h0);
      rd(STATUS_OFF, 32'h1 << (ST_HOME_LSB + c), 32'hf0);
      wr(STATUS_OFF, 32'hf0);
    end
    $display("homing test done");
    print_verdict();
  end
endmodule

/* axis_pkg.sv */
// constants, register map and carrier types for the motion block
package axis_pkg;

  localparam int          AXES          = 4;
  localparam int          GPI_COUNT     = 24;
  localparam int          GPO_COUNT     = 16;
  localparam int          CLK_MHZ       = 100;
  localparam int          LIMIT_MIN_NS  = 600;
  // least time rounds up to whole cycles
  localparam int          LIMIT_CYCLES  = (LIMIT_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int          HOME_SLOW_DIV = 5;

  // register byte offsets
  localparam logic [11:0] CTRL_OFF      = 12'h000;
  localparam logic [11:0] STATUS_OFF    = 12'h004;
  localparam logic [11:0] MASK_OFF      = 12'h008;
  localparam logic [11:0] GPO_OFF       = 12'h00c;
  localparam logic [11:0] GPI_OFF       = 12'h010;
  localparam logic [11:0] SPINDLE_OFF   = 12'h014;
  localparam logic [11:0] LIMIT_OFF     = 12'h018;
  localparam logic [11:0] AXIS_BASE     = 12'h040;
  localparam logic [11:0] AXIS_STRIDE   = 12'h010;
  localparam logic [3:0]  AX_MODE_OFF   = 4'h0;
  localparam logic [3:0]  AX_VEL_OFF    = 4'h4;
  localparam logic [3:0]  AX_ACC_OFF    = 4'h8;
  localparam logic [3:0]  AX_POS_OFF    = 4'hc;

  // field positions
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          CTRL_OVR_LSB  = 4;
  localparam int          CTRL_PWM_LSB  = 8;
  localparam int          ST_LIM_LSB    = 0;
  localparam int          ST_HOME_LSB   = 4;
  localparam int          AX_SEL_LSB    = 8;

  // reset values
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
  localparam logic [15:0] VEL_RST       = 16'h0000;
  localparam logic [15:0] ACC_RST       = 16'h0001;
  localparam logic [7:0]  SPINDLE_RST   = 8'h00;

  typedef enum logic [1:0] {
    MODE_INIT = 2'b00,
    MODE_JOG  = 2'b01,
    MODE_HOME = 2'b10
  } mode_type;

  typedef enum logic [2:0] {
    HOME_IDLE  = 3'b000,
    HOME_SEEK  = 3'b001,
    HOME_BACK  = 3'b010,
    HOME_INDEX = 3'b011
  } home_state_type;

  typedef struct packed {
    logic encoder_phase_first;
    logic encoder_phase_second;
    logic encoder_index_pulse;
  } encoder_pins_type;

  typedef struct packed {
    logic [15:0] level;
    logic        pwm;
    logic        pwm_sign;
  } motor_out_type;

endpackage

/* quad_decoder.sv */
// quadrature decoder for one axis: synchronises pins, emits count and index pulses
`timescale 1ns/1ps
module quad_decoder
  import axis_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire encoder_pins_type pins,
  output logic                  count_up,
  output logic                  count_down,
  output logic                  index_seen
);

  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic [2:0] prev_reg;

  // true when the step old->new follows first-phase-leads order
  function automatic logic leads_first(input logic [1:0] old_ab, input logic [1:0] new_ab);
    unique case (old_ab)
      2'b00:   leads_first = (new_ab == 2'b10);
      2'b10:   leads_first = (new_ab == 2'b11);
      2'b11:   leads_first = (new_ab == 2'b01);
      default: leads_first = (new_ab == 2'b00);
    endcase
  endfunction

  // two flops before anything looks at the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 3'h0;
      sync_reg <= 3'h0;
      prev_reg <= 3'h0;
    end else begin
      meta_reg <= pins;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // every edge of either phase counts; a step on both at once is noise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_up   <= 1'b0;
      count_down <= 1'b0;
      index_seen <= 1'b0;
    end else begin
      count_up   <= (^(sync_reg[2:1] ^ prev_reg[2:1]))
                    && leads_first(prev_reg[2:1], sync_reg[2:1]);
      count_down <= (^(sync_reg[2:1] ^ prev_reg[2:1]))
                    && leads_first(sync_reg[2:1], prev_reg[2:1]);
      index_seen <= sync_reg[0] && !prev_reg[0];
    end
  end

endmodule
